// file: rtl/hrrh_pkg.sv
/*
  constants, carrier structs and state type for the holding register request handler.
  assumes a byte-level serial front end on the same clock and a word-wide holding register store.
*/
package hrrh_pkg;

  // ===========================================================================
  // function codes and fields
  localparam logic [7:0] FN_READ = 8'h03;
  localparam logic [7:0] FN_WRITE = 8'h06;
  localparam logic [7:0] FN_DIAG = 8'h08;
  localparam logic [15:0] DIAG_ECHO = 16'h0000;
  localparam logic [7:0] BCAST_ADDR = 8'h00;
  localparam logic [15:0] MAX_POINTS = 16'h007d;
  localparam logic [15:0] NO_POINTS = 16'h0000;
  // documented register number = address field + this base
  localparam int unsigned HR_NUMBER_BASE = 32'h0000_9c41;

  // ===========================================================================
  // frame layout
  localparam logic [3:0] QUERY_LEN = 4'h8;
  localparam logic [3:0] RX_CNT_OVF = 4'h9;
  localparam logic [2:0] POS_SLAVE = 3'h0;
  localparam logic [2:0] POS_FUNC = 3'h1;
  localparam logic [2:0] POS_A_HI = 3'h2;
  localparam logic [2:0] POS_A_LO = 3'h3;
  localparam logic [2:0] POS_B_HI = 3'h4;
  localparam logic [2:0] POS_B_LO = 3'h5;
  localparam logic [2:0] POS_LAST = 3'h7;
  localparam logic [2:0] HDR_LAST = 3'h2;

  // ===========================================================================
  // check value
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'ha001;
  localparam logic [15:0] CRC_GOOD = 16'h0000;

  // ===========================================================================
  // carriers
  typedef struct packed {
    logic valid;
    logic last;
    logic [7:0] data;
  } hrrh_byte_t;

  typedef struct packed {
    logic rdEn;
    logic wrEn;
    logic [15:0] addr;
    logic [15:0] wrData;
  } hrrh_store_t;

  typedef enum logic [3:0] {
    ST_RECV,
    ST_EVAL,
    ST_ECHO,
    ST_HDR,
    ST_FETCH,
    ST_WAIT,
    ST_DATA_HI,
    ST_DATA_LO,
    ST_CRC_LO,
    ST_CRC_HI
  } hrrh_state_t;

endpackage : hrrh_pkg

// file: rtl/hrrh_crc16.sv
/*
  one-byte update of the reflected 16-bit check value, low bit first.
  assumes the caller holds the running value and seeds it with the initial value.
*/
`timescale 1ns/10ps
module hrrh_crc16 (
  input wire logic [15:0] crcIn,
  input wire logic [7:0] dataIn,
  output logic [15:0] crcOut
);

  // ===========================================================================
  // bitwise shift over eight data bits
  always_comb begin
    logic [15:0] c;
    c = crcIn ^ {8'h00, dataIn};
    for (int i = 0; i < 8; i++) begin
      if (c[0]) begin
        c = (c >> 1) ^ hrrh_pkg::CRC_POLY;
      end else begin
        c = c >> 1;
      end
    end
    crcOut = c;
  end

endmodule : hrrh_crc16

// file: rtl/hrrh_request_handler.sv
/*
  slave-side request handler: collects an eight-byte query, checks it, and answers
  register read, single register write and diagnostic echo queries.
  assumes received bytes arrive on sys_clk with a last mark at frame end, a transmitter
  that takes a byte when txReady is high, and a store whose read data is valid in the
  same cycle as the read strobe.
*/
`timescale 1ns/10ps
// Behaviour
// - a read query is slave address, code 03, start address high first, count high first, check low first.
// - a read query with slave address zero is not treated as a read.
// - the address field equals the documented register number minus 40001 and goes to the store as is.
// - a read may ask for at most 125 registers, larger counts are not served.
// - a read answer is slave address, code 03, byte count twice the count, data, then the check value.
// - read data goes out high byte then low byte, registers ascending from the start address.
// - a single write query is slave address, code 06, address high first, data high first, check low first.
// - the two data bytes of a single write are written whole into the addressed register.
// - a single write with slave address zero is performed whatever the own address is.
// - an addressed single write is answered by repeating the query byte for byte.
// - no answer is sent for any broadcast query.
// - a diagnostic query with code 08 and subfunction 0000 is echoed unchanged.
// - the check value is computed over the message and appended low byte then high byte.
module hrrh_request_handler (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [7:0] ownAddr,
  input wire hrrh_pkg::hrrh_byte_t rxByte,
  input wire logic txReady,
  input wire logic [15:0] storeRdData,
  output hrrh_pkg::hrrh_byte_t txByte,
  output hrrh_pkg::hrrh_store_t storeReq,
  output logic busy
);

  // ===========================================================================
  // declarations
  hrrh_pkg::hrrh_state_t state_r;
  hrrh_pkg::hrrh_state_t state_nxt;
  hrrh_pkg::hrrh_byte_t txByte_r;
  hrrh_pkg::hrrh_store_t storeReq_r;
  logic [7:0] frame [0:7];
  logic [3:0] rxCnt_r;
  logic [15:0] rxCrc_r;
  logic [15:0] rxCrc_nxt;
  logic [15:0] txCrc_r;
  logic [15:0] txCrc_nxt;
  logic [2:0] idx_r;
  logic [6:0] regIdx_r;
  logic [15:0] word_r;
  logic busy_r;
  logic [7:0] fnCode;
  logic [15:0] fieldA;
  logic [15:0] fieldB;
  logic frameOk;
  logic isBcast;
  logic isOwn;
  logic doRead;
  logic doWrite;
  logic doDiag;
  logic doEcho;
  logic txFree;
  logic txLoad;
  logic txLoadLast;
  logic [7:0] txLoadData;
  logic [6:0] regNext;

  assign txByte = txByte_r;
  assign storeReq = storeReq_r;
  assign busy = busy_r;

  // ===========================================================================
  // query decode
  assign fnCode = frame[hrrh_pkg::POS_FUNC];
  assign fieldA = {frame[hrrh_pkg::POS_A_HI], frame[hrrh_pkg::POS_A_LO]};
  assign fieldB = {frame[hrrh_pkg::POS_B_HI], frame[hrrh_pkg::POS_B_LO]};
  assign frameOk = (rxCnt_r == hrrh_pkg::QUERY_LEN) && (rxCrc_r == hrrh_pkg::CRC_GOOD);
  assign isBcast = frame[hrrh_pkg::POS_SLAVE] == hrrh_pkg::BCAST_ADDR;
  assign isOwn = (frame[hrrh_pkg::POS_SLAVE] == ownAddr) && !isBcast;
  assign doRead = frameOk && isOwn && (fnCode == hrrh_pkg::FN_READ)
    && (fieldB != hrrh_pkg::NO_POINTS) && (fieldB <= hrrh_pkg::MAX_POINTS);
  assign doWrite = frameOk && (isOwn || isBcast) && (fnCode == hrrh_pkg::FN_WRITE);
  assign doDiag = frameOk && isOwn && (fnCode == hrrh_pkg::FN_DIAG) && (fieldA == hrrh_pkg::DIAG_ECHO);
  assign doEcho = doDiag || (doWrite && !isBcast);
  assign txFree = !txByte_r.valid || txReady;
  assign regNext = regIdx_r + 7'h01;

  // ===========================================================================
  // check value engines
  hrrh_crc16 rxCrcUnit (
    .crcIn(rxCrc_r),
    .dataIn(rxByte.data),
    .crcOut(rxCrc_nxt)
  );

  hrrh_crc16 txCrcUnit (
    .crcIn(txCrc_r),
    .dataIn(txLoadData),
    .crcOut(txCrc_nxt)
  );

  // ===========================================================================
  // sequencer
  always_comb begin
    state_nxt = state_r;
    txLoad = 1'b0;
    txLoadLast = 1'b0;
    txLoadData = 8'h00;
    unique case (state_r)
      hrrh_pkg::ST_RECV: begin
        if (rxByte.valid && rxByte.last) begin
          state_nxt = hrrh_pkg::ST_EVAL;
        end
      end
      hrrh_pkg::ST_EVAL: begin
        if (doRead) begin
          state_nxt = hrrh_pkg::ST_HDR;
        end else if (doEcho) begin
          state_nxt = hrrh_pkg::ST_ECHO;
        end else begin
          state_nxt = hrrh_pkg::ST_RECV;
        end
      end
      hrrh_pkg::ST_ECHO: begin
        if (txFree) begin
          txLoad = 1'b1;
          txLoadData = frame[idx_r];
          txLoadLast = idx_r == hrrh_pkg::POS_LAST;
          if (idx_r == hrrh_pkg::POS_LAST) begin
            state_nxt = hrrh_pkg::ST_RECV;
          end
        end
      end
      hrrh_pkg::ST_HDR: begin
        if (txFree) begin
          txLoad = 1'b1;
          unique case (idx_r)
            hrrh_pkg::POS_SLAVE: txLoadData = frame[hrrh_pkg::POS_SLAVE];
            hrrh_pkg::POS_FUNC: txLoadData = hrrh_pkg::FN_READ;
            default: txLoadData = {fieldB[6:0], 1'b0};
          endcase
          if (idx_r == hrrh_pkg::HDR_LAST) begin
            state_nxt = hrrh_pkg::ST_FETCH;
          end
        end
      end
      hrrh_pkg::ST_FETCH: begin
        state_nxt = hrrh_pkg::ST_WAIT;
      end
      hrrh_pkg::ST_WAIT: begin
        state_nxt = hrrh_pkg::ST_DATA_HI;
      end
      hrrh_pkg::ST_DATA_HI: begin
        if (txFree) begin
          txLoad = 1'b1;
          txLoadData = word_r[15:8];
          state_nxt = hrrh_pkg::ST_DATA_LO;
        end
      end
      hrrh_pkg::ST_DATA_LO: begin
        if (txFree) begin
          txLoad = 1'b1;
          txLoadData = word_r[7:0];
          if (regNext == fieldB[6:0]) begin
            state_nxt = hrrh_pkg::ST_CRC_LO;
          end else begin
            state_nxt = hrrh_pkg::ST_FETCH;
          end
        end
      end
      hrrh_pkg::ST_CRC_LO: begin
        if (txFree) begin
          txLoad = 1'b1;
          txLoadData = txCrc_r[7:0];
          state_nxt = hrrh_pkg::ST_CRC_HI;
        end
      end
      hrrh_pkg::ST_CRC_HI: begin
        if (txFree) begin
          txLoad = 1'b1;
          txLoadData = txCrc_r[15:8];
          txLoadLast = 1'b1;
          state_nxt = hrrh_pkg::ST_RECV;
        end
      end
      default: begin
        state_nxt = hrrh_pkg::ST_RECV;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= hrrh_pkg::ST_RECV;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_r <= 1'b0;
    end else begin
      busy_r <= state_nxt != hrrh_pkg::ST_RECV;
    end
  end

  // ===========================================================================
  // receive buffer and check
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rxCnt_r <= 4'h0;
      rxCrc_r <= hrrh_pkg::CRC_INIT;
    end else if (state_r == hrrh_pkg::ST_EVAL) begin
      rxCnt_r <= 4'h0;
      rxCrc_r <= hrrh_pkg::CRC_INIT;
    end else if (state_r == hrrh_pkg::ST_RECV && rxByte.valid) begin
      rxCrc_r <= rxCrc_nxt;
      if (rxCnt_r != hrrh_pkg::RX_CNT_OVF) begin
        rxCnt_r <= rxCnt_r + 4'h1;
      end
    end
  end

  generate
    for (genvar g = 0; g < 8; g++) begin : gFrame
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          frame[g] <= 8'h00;
        end else if (state_r == hrrh_pkg::ST_RECV && rxByte.valid && rxCnt_r == 4'(g)) begin
          frame[g] <= rxByte.data;
        end
      end
    end
  endgenerate

  // ===========================================================================
  // transmit byte register and response check
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      txByte_r <= '0;
    end else if (txLoad) begin
      txByte_r.valid <= 1'b1;
      txByte_r.last <= txLoadLast;
      txByte_r.data <= txLoadData;
    end else if (txReady) begin
      txByte_r.valid <= 1'b0;
      txByte_r.last <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      txCrc_r <= hrrh_pkg::CRC_INIT;
    end else if (state_r == hrrh_pkg::ST_EVAL) begin
      txCrc_r <= hrrh_pkg::CRC_INIT;
    end else if (txLoad && state_r != hrrh_pkg::ST_CRC_LO && state_r != hrrh_pkg::ST_CRC_HI) begin
      txCrc_r <= txCrc_nxt;
    end
  end

  // ===========================================================================
  // byte and register indices
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      idx_r <= 3'h0;
    end else if (state_r == hrrh_pkg::ST_EVAL) begin
      idx_r <= 3'h0;
    end else if (txLoad && (state_r == hrrh_pkg::ST_ECHO || state_r == hrrh_pkg::ST_HDR)) begin
      idx_r <= idx_r + 3'h1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      regIdx_r <= 7'h00;
    end else if (state_r == hrrh_pkg::ST_EVAL) begin
      regIdx_r <= 7'h00;
    end else if (txLoad && state_r == hrrh_pkg::ST_DATA_LO) begin
      regIdx_r <= regNext;
    end
  end

  // ===========================================================================
  // holding register store access
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      storeReq_r <= '0;
    end else begin
      storeReq_r.rdEn <= state_r == hrrh_pkg::ST_FETCH;
      storeReq_r.wrEn <= (state_r == hrrh_pkg::ST_EVAL) && doWrite;
      if (state_r == hrrh_pkg::ST_FETCH) begin
        storeReq_r.addr <= fieldA + {9'h000, regIdx_r};
      end else if (state_r == hrrh_pkg::ST_EVAL) begin
        storeReq_r.addr <= fieldA;
        storeReq_r.wrData <= fieldB;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      word_r <= 16'h0000;
    end else if (state_r == hrrh_pkg::ST_WAIT) begin
      word_r <= storeRdData;
    end
  end

endmodule : hrrh_request_handler

// file: test/hrrh_request_handler_sva.sv
/* checker for the request handler ports.
   assumes sys_clk and active low rst_n of the handler. */
`timescale 1ns/10ps
module hrrh_request_handler_sva (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [7:0] ownAddr,
  input wire hrrh_pkg::hrrh_byte_t rxByte,
  input wire logic txReady,
  input wire logic [15:0] storeRdData,
  input wire hrrh_pkg::hrrh_byte_t txByte,
  input wire hrrh_pkg::hrrh_store_t storeReq,
  input wire logic busy
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  // ===========================================================================
  // properties
  sequence s_last_in;
    rxByte.valid && rxByte.last && !busy;
  endsequence
  sequence s_tx_end;
    txByte.valid && txByte.last && txReady;
  endsequence
  property p_busy_rise; s_last_in |=> busy; endproperty
  property p_tx_hold; txByte.valid && !txReady |=> $stable(txByte); endproperty
  property p_tx_cause; $rose(txByte.valid) |-> $past(busy); endproperty
  property p_tx_end; s_tx_end |=> !txByte.valid; endproperty
  property p_wr_once; storeReq.wrEn |=> !storeReq.wrEn; endproperty
  property p_rd_gap; storeReq.rdEn |=> !storeReq.rdEn [*3]; endproperty
  property p_excl; !(storeReq.rdEn && storeReq.wrEn); endproperty
  property p_req_busy; storeReq.rdEn || storeReq.wrEn |-> $past(busy); endproperty
  a_busy_rise: assert property (p_busy_rise) else $error("frame end without busy");
  a_tx_hold: assert property (p_tx_hold) else $error("byte changed while stalled");
  a_tx_cause: assert property (p_tx_cause) else $error("byte offered while idle");
  a_tx_end: assert property (p_tx_end) else $error("byte after last byte");
  a_wr_once: assert property (p_wr_once) else $error("write strobe too long");
  a_rd_gap: assert property (p_rd_gap) else $error("reads too close");
  a_excl: assert property (p_excl) else $error("read and write together");
  a_req_busy: assert property (p_req_busy) else $error("store access while idle");
endmodule : hrrh_request_handler_sva
bind hrrh_request_handler hrrh_request_handler_sva hrrh_request_handler_sva_i (.sys_clk, .rst_n, .ownAddr,
  .rxByte, .txReady, .storeRdData, .txByte, .storeReq, .busy);

// file: test/hrrh_master_model.sv
/* remote master: sends query bytes, takes answer bytes with random stalls.
   assumes the bench waits for the handler to go idle between queries. */
`timescale 1ns/10ps
module hrrh_master_model (
  input wire logic sys_clk,
  input wire hrrh_pkg::hrrh_byte_t txByte,
  output hrrh_pkg::hrrh_byte_t rxByte,
  output logic txReady
);
  logic [8:0] rsp[$];
  initial begin
    rxByte = '0;
    txReady = 1'b0;
  end
  // collect answer bytes
  always @(posedge sys_clk) begin
    if (txByte.valid && txReady) rsp.push_back({txByte.last, txByte.data});
    #1 txReady <= ($urandom % 4) != 0;
  end
  // one byte per cycle, last marked, line inverted after release
  task automatic send(input logic [7:0] q[$]);
    foreach (q[i]) begin
      @(posedge sys_clk);
      #1 rxByte <= {1'b1, i == q.size() - 1, q[i]};
    end
    @(posedge sys_clk);
    #1 rxByte <= {2'b00, ~q[q.size() - 1]};
  endtask : send
endmodule : hrrh_master_model

// file: test/hrrh_request_handler_test.sv
/* self-checking bench for the request handler.
   assumes a behavioural store and the master model. */
`timescale 1ns/10ps
module hrrh_request_handler_test;
  typedef logic [7:0] hrrh_bytes_t[$];
  logic sys_clk, rst_n, txReady, busy;
  logic [7:0] ownAddr;
  logic [15:0] mem [0:255];
  hrrh_pkg::hrrh_byte_t rxByte, txByte;
  hrrh_pkg::hrrh_store_t storeReq;
  wire logic [15:0] storeRdData = mem[storeReq.addr[7:0]];
  int failures, n_checks;
  hrrh_request_handler hrrh_request_handler_i (.sys_clk, .rst_n, .ownAddr, .rxByte, .txReady,
    .storeRdData, .txByte, .storeReq, .busy);
  hrrh_master_model hrrh_master_model_i (.sys_clk, .txByte, .rxByte, .txReady);
  always @(posedge sys_clk) if (storeReq.wrEn) mem[storeReq.addr[7:0]] <= storeReq.wrData;
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // ===========================================================================
  // helpers
  function automatic hrrh_bytes_t seal(hrrh_bytes_t q);
    logic [15:0] c = hrrh_pkg::CRC_INIT;
    foreach (q[i]) begin
      c ^= {8'h00, q[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ hrrh_pkg::CRC_POLY : c >> 1;
    end
    return {q, c[7:0], c[15:8]};
  endfunction : seal
  task automatic chk(input logic [31:0] got, exp, input string m);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  task automatic run(input logic [7:0] s, f, input logic [15:0] a, b, input bit bad, ok);
    hrrh_bytes_t q, e;
    logic [15:0] old;
    logic [7:0] k;
    int n;
    q = seal('{s, f, a[15:8], a[7:0], b[15:8], b[7:0]});
    if (bad) q[6] = ~q[6];
    old = mem[a[7:0]];
    e.delete();
    if (ok && f == 8'h03) begin
      e = '{s, f, {b[6:0], 1'b0}};
      for (int i = 0; i < b; i++) begin
        k = a[7:0] + i[7:0];
        e = {e, mem[k][15:8], mem[k][7:0]};
      end
      e = seal(e);
    end else if (ok) e = q;
    hrrh_master_model_i.rsp.delete();
    hrrh_master_model_i.send(q);
    repeat (3) @(posedge sys_clk);
    #2 n = 0;
    while ((busy || txByte.valid) && n < 3000) begin
      @(posedge sys_clk);
      #2 n++;
    end
    if (n >= 3000) begin
      failures++;
      $display("wrong value at %0t: answer timeout", $time);
    end
    chk(hrrh_master_model_i.rsp.size(), e.size(), "answer length");
    foreach (e[i]) if (i < hrrh_master_model_i.rsp.size())
      chk(hrrh_master_model_i.rsp[i], {i == e.size() - 1, e[i]}, "answer byte");
    if (f == 8'h06)
      chk(mem[a[7:0]], (!bad && (s == ownAddr || s == 8'h00)) ? b : old, "store");
    $display("test done slave %h code %h", s, f);
  endtask : run
  task automatic end_of_test;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test
  // ===========================================================================
  // sequence
  initial begin
    logic [7:0] fc [3];
    logic [7:0] f;
    fc = '{8'h03, 8'h06, 8'h08};
    rst_n = 1'b0;
    failures = 0;
    n_checks = 0;
    void'($urandom(64));
    ownAddr = 8'($urandom_range(1, 247));
    foreach (mem[i]) mem[i] = 16'($urandom);
    repeat (3) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    run(ownAddr, 8'h03, 16'h0001, 16'h0001, 0, 1);
    run(ownAddr, 8'h03, 16'h0000, 16'h007d, 0, 1);
    run(ownAddr, 8'h03, 16'h0000, 16'h0000, 0, 0);
    run(ownAddr, 8'h03, 16'h0000, 16'h007e, 0, 0);
    run(8'h00, 8'h03, 16'h0000, 16'h0002, 0, 0);
    run(ownAddr, 8'h06, 16'h0005, 16'h1770, 0, 1);
    run(8'h00, 8'h06, 16'h0006, 16'h0bb8, 0, 0);
    run(ownAddr + 8'h01, 8'h06, 16'h0007, 16'h03e8, 0, 0);
    run(ownAddr, 8'h06, 16'h0008, 16'h1234, 1, 0);
    run(ownAddr, 8'h08, 16'h0000, 16'h5a5a, 0, 1);
    run(ownAddr, 8'h08, 16'h0001, 16'h5a5a, 0, 0);
    run(8'h00, 8'h08, 16'h0000, 16'h5a5a, 0, 0);
    run(ownAddr, 8'h10, 16'h0000, 16'h0001, 0, 0);
    repeat (20) begin
      f = fc[$urandom % 3];
      run(ownAddr, f, f == 8'h08 ? 16'h0000 : 16'($urandom_range(0, 127)),
        f == 8'h03 ? 16'($urandom_range(1, 125)) : 16'($urandom), 0, 1);
    end
    end_of_test();
  end
  initial begin
    #400000;
    failures++;
    $display("wrong value at %0t: watchdog expired", $time);
    end_of_test();
  end
endmodule : hrrh_request_handler_test
